// file: src/cpsc_pkg.sv
/*
 * Constants, register map and carrier types for the cable status and
 * control register bank. Assumes a 20 MHz system clock and 32-bit Wishbone.
 */
// Behaviour
// - Six-bit read-only node number from self-ID
// - Read-only flag set when node is root
// - Root hold-off bit requests root at next reset
// - Bus reset request bit starts reset soon
// - Six-bit read/write gap count
// - Top speed code always reads 01
// - Port total always reads 0011
// - Per-port line states, 00 at reset or busy
// - Per-port downstream flag, 1 for child
// - Per-port connection status, 1 when connected
// - Loop fault flag, write 0 clears, re-sets
// - Power trip clears both cable power copies
// - Power trip sets the power drop flag
// - Drop flag cleared by reset or write 0
// - Locally originated reset flag, sent in self-ID
// - Read-only bid flag for manager role
// - Three power class bits, index 0 MSB
// - Mode pin high: no short resets, treat long
// - Mode pin low: short request arbitrates, short reset
// - Short mode recognises remote short, keeps long
// - Long reset lasts 167 to 250 us
// - Short reset arbitration 1.3 to 80 us
package cpsc_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int LONG_RESET_MIN_NS = 167000;
  localparam int LONG_RESET_MAX_NS = 250000;
  localparam int ARB_MAX_NS = 80000;
  localparam int SHORT_RESET_MIN_NS = 1300;
  localparam int LONG_RESET_CYC = (LONG_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARB_MAX_CYC = ARB_MAX_NS / CLK_PERIOD_NS;
  localparam int SHORT_RESET_CYC = (SHORT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam int NUM_PORTS = 3;
  localparam int ADR_W = 6;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_IDENT = 4'h0;
  localparam logic [3:0] IDX_CTRL = 4'h1;
  localparam logic [3:0] IDX_CAPS = 4'h2;
  localparam logic [3:0] IDX_PORT0 = 4'h3;
  localparam logic [3:0] IDX_PORT2 = 4'h5;
  localparam logic [3:0] IDX_EVENT = 4'h6;
  localparam logic [3:0] IDX_POWER = 4'h7;
  localparam logic [3:0] IDX_SPARE = 4'h8;
  localparam logic [3:0] IDX_SHORT = 4'h9;

  // Field positions
  localparam int B_ROOT = 6;
  localparam int B_CPS0 = 7;
  localparam int B_RHB = 0;
  localparam int B_IBR = 1;
  localparam int B_GAP = 2;
  localparam int B_NP = 4;
  localparam int B_CHILD = 4;
  localparam int B_CONN = 5;
  localparam int B_LOOP = 0;
  localparam int B_DROP = 1;
  localparam int B_CPS6 = 2;
  localparam int B_IR = 3;
  localparam int B_BID = 7;
  localparam int B_PC = 4;
  localparam int B_SHORT_RESET_REQUEST = 7;

  localparam logic [1:0] TOP_SPEED_CODE = 2'h1;
  localparam logic [3:0] PORT_TOTAL = 4'h3;
  localparam logic [1:0] LINE_INVALID = 2'h0;
  localparam logic [5:0] GAP_RESET = 6'h00;

  typedef enum logic [1:0] {
    CPSC_IDLE = 2'b00,
    CPSC_LONG = 2'b01,
    CPSC_ARB = 2'b10,
    CPSC_SHORT = 2'b11
  } cpsc_state_type;

  typedef struct packed {
    logic busy;
    logic connected;
    logic child;
    logic [1:0] b_state;
    logic [1:0] a_state;
  } cpsc_port_type;

  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic stb;
    logic cyc;
  } cpsc_wb_req_type;
endpackage

// file: src/cpsc_regs.sv
/*
 * Register bank and bus reset sequencer of a three-port cable PHY.
 * Assumes a classic Wishbone master on clk_i and a PHY core on the same
 * clock; the mode, cable power, power class and bid pins are asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
module cpsc_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire cpsc_pkg::cpsc_wb_req_type wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // PHY core status, same clock
  input wire logic [5:0] node_number_i,
  input wire logic is_root_i,
  input wire cpsc_pkg::cpsc_port_type [cpsc_pkg::NUM_PORTS-1:0] ports_i,
  input wire logic loop_timeout_i,
  input wire logic remote_reset_i,
  input wire logic remote_short_i,
  input wire logic arb_won_i,
  // Asynchronous pins
  input wire logic cable_power_ok_i,
  input wire logic short_reset_mode_pin_i,
  input wire logic bid_strap_i,
  input wire logic [2:0] power_class_i,
  // Controls toward the PHY core
  output logic root_holdoff_o,
  output logic [5:0] gap_count_o,
  output logic long_reset_drive_o,
  output logic arb_request_o,
  output logic short_reset_drive_o,
  output logic remote_as_short_o,
  output logic reset_originated_here_o
);
  import cpsc_pkg::*;

  typedef struct packed {
    cpsc_state_type st;
    logic [CNT_W-1:0] cnt;
    logic [31:0] dat;
    logic ack;
    logic root_holdoff;
    logic bus_reset_request;
    logic [5:0] gap;
    logic loop;
    logic drop;
    logic ir;
    logic short_reset_request;
    logic [1:0] cps_s;
    logic [1:0] mode_s;
    logic [1:0] bid_s;
    logic [2:0] pc_s1;
    logic [2:0] pc_s2;
    logic cps_ok;
    logic bid;
    logic strap_done;
    logic remote_d;
    logic remote_short_o;
  } cpsc_regs_type;

  cpsc_regs_type s_r;
  cpsc_regs_type s_nxt;
  logic [3:0] idx;
  logic sel_ok;
  logic access;
  logic wr;
  logic [7:0] wbyte;
  logic mode_long;

  // Only the aligned word of a register is mapped
  function automatic logic [7:0] read_reg(input logic [3:0] i, input cpsc_regs_type s,
                                         input logic [5:0] nn, input logic root,
                                         input cpsc_port_type [NUM_PORTS-1:0] p);
    logic [7:0] v;
    int k;
    v = 8'h00;
    k = 0;
    if (i == IDX_IDENT) begin
      v[5:0] = nn;
      v[B_ROOT] = root;
      v[B_CPS0] = s.cps_ok;
    end else if (i == IDX_CTRL) begin
      v[B_RHB] = s.root_holdoff;
      v[B_IBR] = s.bus_reset_request;
      v[B_GAP +: 6] = s.gap;
    end else if (i == IDX_CAPS) begin
      v[1:0] = TOP_SPEED_CODE;
      v[B_NP +: 4] = PORT_TOTAL;
    end else if (i >= IDX_PORT0 && i <= IDX_PORT2) begin
      k = int'(i - IDX_PORT0);
      // Line state is only meaningful while the pair is idle
      if (p[k].busy || s.strap_done == 1'b0) begin
        v[3:0] = {LINE_INVALID, LINE_INVALID};
      end else begin
        v[3:0] = {p[k].b_state, p[k].a_state};
      end
      v[B_CHILD] = p[k].child;
      v[B_CONN] = p[k].connected;
    end else if (i == IDX_EVENT) begin
      v[B_LOOP] = s.loop;
      v[B_DROP] = s.drop;
      v[B_CPS6] = s.cps_ok;
      v[B_IR] = s.ir;
      v[B_BID] = s.bid;
    end else if (i == IDX_POWER) begin
      v[B_PC +: 3] = {s.pc_s2[0], s.pc_s2[1], s.pc_s2[2]};
      v[B_BID] = s.bid;
    end else if (i == IDX_SHORT) begin
      v[B_SHORT_RESET_REQUEST] = s.short_reset_request;
    end
    return v;
  endfunction

  assign idx = wb_req_i.adr[ADR_W-1:2];
  assign sel_ok = wb_req_i.adr[1:0] == 2'b00;
  assign access = wb_req_i.cyc && wb_req_i.stb && !s_r.ack;
  assign wr = access && wb_req_i.we && wb_req_i.sel[0] && sel_ok;
  assign wbyte = wb_req_i.dat[7:0];
  assign mode_long = s_r.mode_s[1];

  always_comb begin
    s_nxt = s_r;
    // Two-flop synchronisers; only the second stage feeds logic
    s_nxt.cps_s = {s_r.cps_s[0], cable_power_ok_i};
    s_nxt.mode_s = {s_r.mode_s[0], short_reset_mode_pin_i};
    s_nxt.bid_s = {s_r.bid_s[0], bid_strap_i};
    s_nxt.pc_s1 = power_class_i;
    s_nxt.pc_s2 = s_r.pc_s1;
    s_nxt.cps_ok = s_r.cps_s[1];
    // Bid strap caught once the synchroniser has settled after reset
    s_nxt.strap_done = 1'b1;
    if (!s_r.strap_done) begin
      s_nxt.bid = s_r.bid_s[1];
    end

    // Bus slave: one wait state, unmapped words read zero
    s_nxt.ack = access;
    s_nxt.dat = 32'h0000_0000;
    if (access && !wb_req_i.we && sel_ok) begin
      s_nxt.dat = {24'h00_0000, read_reg(idx, s_r, node_number_i, is_root_i, ports_i)};
    end
    if (wr && idx == IDX_CTRL) begin
      s_nxt.root_holdoff = wbyte[B_RHB];
      s_nxt.bus_reset_request = wbyte[B_IBR];
      s_nxt.gap = wbyte[B_GAP +: 6];
    end
    if (wr && idx == IDX_EVENT) begin
      if (!wbyte[B_LOOP]) begin
        s_nxt.loop = 1'b0;
      end
      if (!wbyte[B_DROP]) begin
        s_nxt.drop = 1'b0;
      end
      s_nxt.ir = wbyte[B_IR];
    end
    if (wr && idx == IDX_SHORT) begin
      s_nxt.short_reset_request = wbyte[B_SHORT_RESET_REQUEST];
    end

    // Hardware events win over a clearing write in the same cycle
    if (loop_timeout_i) begin
      s_nxt.loop = 1'b1;
    end
    // Power copy is still zero in the first cycle after reset
    if (!s_r.cps_ok && s_r.strap_done) begin
      s_nxt.drop = 1'b1;
    end

    // Remote reset: only an arbitrated one in short mode is treated as short
    s_nxt.remote_d = remote_reset_i;
    if (remote_reset_i && !s_r.remote_d) begin
      s_nxt.ir = 1'b0;
      s_nxt.remote_short_o = remote_short_i && !mode_long;
    end

    s_nxt.cnt = s_r.cnt + 1'b1;
    case (s_r.st)
      CPSC_IDLE: begin
        s_nxt.cnt = '0;
        if (s_r.bus_reset_request) begin
          s_nxt.st = CPSC_LONG;
          s_nxt.bus_reset_request = 1'b0;
          s_nxt.ir = 1'b1;
        end else if (s_r.short_reset_request && mode_long) begin
          s_nxt.short_reset_request = 1'b0;
        end else if (s_r.short_reset_request) begin
          s_nxt.st = CPSC_ARB;
          s_nxt.short_reset_request = 1'b0;
        end
      end
      CPSC_ARB: begin
        if (arb_won_i) begin
          s_nxt.st = CPSC_SHORT;
          s_nxt.cnt = '0;
          s_nxt.ir = 1'b1;
        end else if (s_r.cnt == CNT_W'(ARB_MAX_CYC - 1)) begin
          // Arbitration lost for too long: fall back to a full reset
          s_nxt.st = CPSC_LONG;
          s_nxt.cnt = '0;
          s_nxt.ir = 1'b1;
        end
      end
      CPSC_SHORT: begin
        if (s_r.cnt == CNT_W'(SHORT_RESET_CYC - 1)) begin
          s_nxt.st = CPSC_IDLE;
        end
      end
      CPSC_LONG: begin
        if (s_r.cnt == CNT_W'(LONG_RESET_CYC - 1)) begin
          s_nxt.st = CPSC_IDLE;
        end
      end
      default: begin
        s_nxt.st = CPSC_IDLE;
      end
    endcase

    if (rst_i) begin
      s_nxt = '0;
      s_nxt.gap = GAP_RESET;
      s_nxt.st = CPSC_IDLE;
      // Synchronisers run through reset so straps are valid at release
      s_nxt.cps_s = {s_r.cps_s[0], cable_power_ok_i};
      s_nxt.mode_s = {s_r.mode_s[0], short_reset_mode_pin_i};
      s_nxt.bid_s = {s_r.bid_s[0], bid_strap_i};
      s_nxt.pc_s1 = power_class_i;
      s_nxt.pc_s2 = s_r.pc_s1;
    end
  end

  always_ff @(posedge clk_i) begin
    s_r <= s_nxt;
  end

  // Drive outputs from flops loaded with the decoded next state
  logic long_q;
  logic arb_q;
  logic short_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      long_q <= 1'b0;
      arb_q <= 1'b0;
      short_q <= 1'b0;
    end else begin
      long_q <= s_nxt.st == CPSC_LONG;
      arb_q <= s_nxt.st == CPSC_ARB;
      short_q <= s_nxt.st == CPSC_SHORT;
    end
  end

  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign root_holdoff_o = s_r.root_holdoff;
  assign gap_count_o = s_r.gap;
  assign long_reset_drive_o = long_q;
  assign arb_request_o = arb_q;
  assign short_reset_drive_o = short_q;
  assign remote_as_short_o = s_r.remote_short_o;
  assign reset_originated_here_o = s_r.ir;

  // Checks next to the logic they guard
  int unsigned long_len;
  always_ff @(posedge clk_i) begin
    if (rst_i || !long_q) begin
      long_len <= 0;
    end else begin
      long_len <= long_len + 1;
    end
  end

  AST_LONG_BOUNDED: assert property (@(posedge clk_i) disable iff (rst_i)
    long_len <= LONG_RESET_MAX_NS / CLK_PERIOD_NS)
    else $error("long reset drive exceeds its maximum");

  AST_LONG_MIN: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(long_q) |-> $past(long_len) >= LONG_RESET_CYC - 1)
    else $error("long reset ended too early");

  AST_SHORT_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(short_q) |-> short_q [*8] ##[1:30] !short_q)
    else $error("short reset length out of bounds");

  AST_NO_SHORT_IN_LONG_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_r.mode_s[1] && s_r.st == CPSC_IDLE && !s_r.bus_reset_request) |=> !arb_q)
    else $error("arbitration started while mode pin high");

  AST_SHORT_RESET_REQUEST_ARB: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_r.st == CPSC_IDLE && !s_r.bus_reset_request && s_r.short_reset_request && !s_r.mode_s[1]) |=> arb_q)
    else $error("short request did not start arbitration");

  AST_IBR_LONG: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_r.st == CPSC_IDLE && s_r.bus_reset_request) |=> ##1 long_q && s_r.ir)
    else $error("reset request did not start long reset");

  AST_DROP_SETS: assert property (@(posedge clk_i) disable iff (rst_i)
    (!s_r.cps_ok && s_r.strap_done) |=> s_r.drop)
    else $error("power drop flag not set while cable power low");

  AST_CPS_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_r.cps_s[1] |=> !s_r.cps_ok)
    else $error("cable power copy not cleared on trip");

  AST_LOOP_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
    loop_timeout_i |=> s_r.loop)
    else $error("loop fault flag lost");

  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  AST_SPEED_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    (access && !wb_req_i.we && sel_ok && idx == IDX_CAPS) |=>
      wb_dat_o == {24'h00_0000, PORT_TOTAL, 2'b00, TOP_SPEED_CODE})
    else $error("capability register reads wrong");

  AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("bits above the byte not zero");
endmodule
`default_nettype wire

// file: tb/cpsc_link_model.sv
/*
 * Link-side bus master model for the cable status register bank.
 * Assumes a classic Wishbone slave with registered ack and read data.
 */
`timescale 1ns/10ps
`default_nettype none
module cpsc_link_model (
  // Bus
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output cpsc_pkg::cpsc_wb_req_type req_o
);
  import cpsc_pkg::*;
  initial req_o = '0;
  // Enter just after a rising edge; request held until ack is sampled
  task automatic xfer(input logic [3:0] idx, input logic we, input logic [7:0] d,
                      output logic [7:0] q);
    req_o <= '{adr: {idx, 2'b00}, dat: {24'h0, d}, sel: 4'h1, we: we, stb: 1'b1, cyc: 1'b1};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i[7:0];
    req_o <= '0;
    // Idle cycle so the slave can drop ack
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// file: tb/cpsc_regs_tb.sv
/*
 * Self-checking bench for the cable status register bank.
 * Assumes the link model as bus master and a 20 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module cpsc_regs_tb;
  import cpsc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  cpsc_wb_req_type req;
  logic [31:0] dat;
  logic ack, root_holdoff, lrst, arb, srst, ras, irh;
  logic [5:0] gap;
  // Port 2 busy, so its line states must read invalid
  cpsc_port_type [NUM_PORTS-1:0] ports = {7'h66, 7'h0f, 7'h39};
  logic cab = 1'b1, mode = 1'b1, loop = 1'b0, won = 1'b0;
  logic [2:0] pcl = 3'b001;
  logic rmt = 1'b0, rsh = 1'b0;
  int miscompares = 0;
  int total_checks = 0;
  int n;
  always #25 clk = ~clk;
  cpsc_link_model link (.clk_i(clk), .ack_i(ack), .dat_i(dat), .req_o(req));
  cpsc_regs dut (.clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack),
    .node_number_i(6'h2a), .is_root_i(1'b1), .ports_i(ports), .loop_timeout_i(loop),
    .remote_reset_i(rmt), .remote_short_i(rsh), .arb_won_i(won),
    .cable_power_ok_i(cab), .short_reset_mode_pin_i(mode), .bid_strap_i(1'b1),
    .power_class_i(pcl), .root_holdoff_o(root_holdoff), .gap_count_o(gap),
    .long_reset_drive_o(lrst), .arb_request_o(arb), .short_reset_drive_o(srst),
    .remote_as_short_o(ras), .reset_originated_here_o(irh));
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [7:0] q;
    link.xfer(i, 1'b1, d, q);
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] e, input string nm);
    logic [7:0] q;
    link.xfer(i, 1'b0, 8'h00, q);
    `CHK(nm, e, q)
  endtask
  function automatic logic pick(input int s);
    return (s == 0) ? lrst : ((s == 1) ? arb : srst);
  endfunction
  // Waits for a drive to rise, then counts its cycles high
  task automatic span(input int s, output int c);
    c = 0;
    while (pick(s) !== 1'b1 && c < 40) begin
      @(posedge clk);
      c++;
    end
    `CHK("drive start", 1'b1, pick(s))
    c = 0;
    while (pick(s) === 1'b1 && c < 5000) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic t_static;
    rd(IDX_IDENT, 8'hea, "ident");
    rd(IDX_IDENT, 8'hea, "root");
    wr(IDX_CAPS, 8'hff);
    rd(IDX_CAPS, 8'h31, "caps");
    rd(IDX_CAPS, 8'h31, "ports");
    rd(IDX_POWER, 8'hc0, "pclass");
    rd(IDX_EVENT, 8'h84, "event");
    wr(IDX_SPARE, 8'hff);
    rd(IDX_SPARE, 8'h00, "spare");
    $display("test static done");
  endtask
  task automatic t_ports;
    rd(IDX_PORT0, 8'h39, "port0");
    rd(4'h4, 8'h0f, "port1");
    rd(IDX_PORT2, 8'h20, "port2");
    $display("test ports done");
  endtask
  task automatic t_ctrl;
    wr(IDX_CTRL, 8'ha9);
    rd(IDX_CTRL, 8'ha9, "ctrl");
    `CHK("gap", 6'h2a, gap)
    `CHK("holdoff", 1'b1, root_holdoff)
    $display("test ctrl done");
  endtask
  task automatic t_power;
    cab <= 1'b0;
    repeat (6) @(posedge clk);
    rd(IDX_IDENT, 8'h6a, "cps off");
    rd(IDX_EVENT, 8'h82, "drop set");
    wr(IDX_EVENT, 8'h00);
    rd(IDX_EVENT, 8'h82, "drop held");
    cab <= 1'b1;
    loop <= 1'b1;
    @(posedge clk);
    loop <= 1'b0;
    repeat (6) @(posedge clk);
    rd(IDX_EVENT, 8'h87, "loop set");
    wr(IDX_EVENT, 8'h00);
    rd(IDX_EVENT, 8'h84, "cleared");
    $display("test power done");
  endtask
  task automatic t_long;
    wr(IDX_CTRL, 8'hab);
    span(0, n);
    `CHK("long len", LONG_RESET_CYC, n)
    rd(IDX_CTRL, 8'ha9, "ibr clear");
    rd(IDX_EVENT, 8'h8c, "origin");
    `CHK("origin pin", 1'b1, irh)
    $display("test long done");
  endtask
  task automatic t_short;
    // Mode pin high: request must be dropped without arbitration
    wr(IDX_SHORT, 8'h80);
    repeat (10) @(posedge clk);
    `CHK("no arb", 1'b0, arb)
    rd(IDX_SHORT, 8'h00, "short_reset_request drop");
    mode <= 1'b0;
    won <= 1'b1;
    repeat (5) @(posedge clk);
    wr(IDX_SHORT, 8'h80);
    span(1, n);
    span(2, n);
    `CHK("short len", SHORT_RESET_CYC, n)
    `CHK("no long", 1'b0, lrst)
    // Remote arbitrated reset: short in short mode, long otherwise
    rmt <= 1'b1;
    rsh <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("remote short", 1'b1, ras)
    `CHK("remote origin", 1'b0, irh)
    rmt <= 1'b0;
    mode <= 1'b1;
    repeat (5) @(posedge clk);
    rmt <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("remote long", 1'b0, ras)
    rmt <= 1'b0;
    rsh <= 1'b0;
    $display("test short done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Extra cycles flush the pin synchronisers
    repeat (4) @(posedge clk);
    t_static();
    t_ports();
    t_ctrl();
    t_power();
    t_long();
    t_short();
    stop_test();
  end
  // Tests need about 4000 cycles; five times that is a hang
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
